// ### inc/dsic_pkg.sv
// Summary of operation
// - TXD feeds transmitter, receiver drives RXD.
// - Effective RTS is pin OR control bit.
// - Transmit TXD data only once CTS active.
// - Half duplex RTS assertion starts training.
// - RLSD only above threshold, never during training.
// - Four threshold choices, host programmable levels.
// - High speed DTR handshake completes on data bit.
// - Low speed DTR enters data if data bit.
// - Low speed answer mode sends answer tone.
// - Low speed controlled carrier follows effective RTS.
// - DTR drop in data mode returns idle.
// - Effective DTR is pin OR control bit.
// - DSR on only in data transfer state.
// - DSR held off in any test mode.
// - DSR status bit mirrors DSR pin.
// - RI pin low during ring on periods.
// - RI status bit mirrors RI pin.
// - Transmit clock at data rate, even duty.
// - Transmit clock source internal, external or slave.
// - External source reproduced on transmit clock.
// - Receive clock at data rate, even duty.
// - Receive clock rises at received bit centre.
package dsic_pkg;

    // ------------------------------------------------------------
    // Widths and clock rate
    // ------------------------------------------------------------
    localparam int CLK_HZ = 50_000_000;
    localparam int ADDR_W = 8;
    localparam int DATA_W = 32;
    localparam int RATE_W = 16;
    localparam int LVL_W  = 8;
    localparam int CTRL_W = 8;
    localparam int CFG_W  = 4;
    localparam int CTS_CNT_W = 8;

    // ------------------------------------------------------------
    // Register offsets
    // ------------------------------------------------------------
    localparam logic [ADDR_W-1:0] OFS_CTRL   = 8'h00;
    localparam logic [ADDR_W-1:0] OFS_CLKCFG = 8'h04;
    localparam logic [ADDR_W-1:0] OFS_THR    = 8'h08;
    localparam logic [ADDR_W-1:0] OFS_RATE   = 8'h0C;
    localparam logic [ADDR_W-1:0] OFS_STATUS = 8'h10;

    // ------------------------------------------------------------
    // Field positions
    // ------------------------------------------------------------
    localparam int CTRL_RTS    = 0;
    localparam int CTRL_DTR    = 1;
    localparam int CTRL_DATA   = 2;
    localparam int CTRL_ANSWER = 3;
    localparam int CTRL_CCAR   = 4;
    localparam int CTRL_LOW    = 5;
    localparam int CTRL_HALF   = 6;
    localparam int CTRL_TEST   = 7;
    localparam int CFG_TXSRC_LSB = 0;
    localparam int CFG_LVL_LSB   = 2;
    localparam int THR_OFF_LSB   = 8;
    localparam int STAT_DSR   = 0;
    localparam int STAT_RI    = 1;
    localparam int STAT_CTS   = 2;
    localparam int STAT_RLSD  = 3;
    localparam int STAT_CAR   = 4;
    localparam int STAT_DATA  = 5;
    localparam int STAT_TRAIN = 6;

    // ------------------------------------------------------------
    // Encodings and reset values
    // ------------------------------------------------------------
    localparam logic [1:0] TXSRC_INT   = 2'h0;
    localparam logic [1:0] TXSRC_EXT   = 2'h1;
    localparam logic [1:0] TXSRC_SLAVE = 2'h2;
    localparam logic [1:0] LVL_HOST    = 2'h3;
    localparam logic [CTRL_W-1:0] CTRL_RST   = 8'h00;
    localparam logic [CFG_W-1:0]  CLKCFG_RST = 4'h0;
    localparam logic [LVL_W-1:0]  THR_ON_RST  = 8'h40;
    localparam logic [LVL_W-1:0]  THR_OFF_RST = 8'h30;
    localparam logic [RATE_W-1:0] RATE_RST    = 16'h0A2C;
    localparam logic [LVL_W-1:0] LVL_ON_TAB  [3] = '{8'h20, 8'h30, 8'h40};
    localparam logic [LVL_W-1:0] LVL_OFF_TAB [3] = '{8'h1A, 8'h28, 8'h36};

    // ------------------------------------------------------------
    // Timing
    // ------------------------------------------------------------
    localparam int CTS_DELAY_NS  = 200;
    localparam int CTS_DELAY_CYC = (CTS_DELAY_NS * (CLK_HZ / 1_000_000) + 999) / 1000;
    localparam int TRAIN_US  = 2000;
    localparam int TRAIN_CYC = TRAIN_US * (CLK_HZ / 1_000_000);

    // Picks a preset level, or the host level when the host setting is chosen.
    function automatic logic [LVL_W-1:0] thr_pick(
        input logic [1:0]       sel,
        input logic [LVL_W-1:0] host,
        input logic             on_level
    );
        logic [LVL_W-1:0] v;
        if (sel == LVL_HOST) begin
            v = host;
        end else if (on_level) begin
            v = LVL_ON_TAB[sel];
        end else begin
            v = LVL_OFF_TAB[sel];
        end
        return v;
    endfunction

endpackage

// ### core/dsic_sync.sv
module dsic_sync #(
    parameter int             W       = 1,
    parameter logic [W-1:0]   RST_VAL = '0
) (
    input  logic          clk,
    input  logic          reset,
    input  logic [W-1:0]  d,
    output logic [W-1:0]  q
);
    import dsic_pkg::*;

    typedef struct packed {
        logic [W-1:0] s1;
        logic [W-1:0] s2;
    } dsic_sync_s;

    dsic_sync_s st_r;
    dsic_sync_s st_nxt;

    // The first stage may go metastable, so only the second stage reads it.
    always_comb begin
        st_nxt    = st_r;
        st_nxt.s1 = d;
        st_nxt.s2 = st_r.s1;
    end

    always_ff @(posedge clk) begin
        if (reset) begin
            st_r <= {RST_VAL, RST_VAL};
        end else begin
            st_r <= st_nxt;
        end
    end

    assign q = st_r.s2;

endmodule

// ### core/dsic_bitclk.sv
module dsic_bitclk (
    input  logic                         clk,
    input  logic                         reset,
    input  logic                         enable,
    input  logic [dsic_pkg::RATE_W-1:0]  half_count,
    output logic                         level,
    output logic                         rise,
    output logic                         fall
);
    import dsic_pkg::*;

    typedef struct packed {
        logic [RATE_W-1:0] cnt;
        logic              lvl;
    } dsic_bitclk_s;

    dsic_bitclk_s st_r;
    dsic_bitclk_s st_nxt;
    logic         wrap;

    // Equal half periods give the even duty; rise and fall warn one edge ahead.
    always_comb begin
        st_nxt = st_r;
        wrap   = enable && (st_r.cnt + 1'b1 >= half_count);
        if (!enable) begin
            st_nxt = '0;
        end else if (wrap) begin
            st_nxt.cnt = '0;
            st_nxt.lvl = !st_r.lvl;
        end else begin
            st_nxt.cnt = st_r.cnt + 1'b1;
        end
    end

    always_ff @(posedge clk) begin
        if (reset) begin
            st_r <= '0;
        end else begin
            st_r <= st_nxt;
        end
    end

    assign level = st_r.lvl;
    assign rise  = wrap && !st_r.lvl;
    assign fall  = wrap && st_r.lvl;

endmodule

// ### core/dsic_top.sv
// The strobed register port and the register offsets were decided locally.
module dsic_top #(
    parameter int TRAIN_CYCLES = dsic_pkg::TRAIN_CYC
) (
    input  logic                         clk,
    input  logic                         reset,
    input  logic [dsic_pkg::ADDR_W-1:0]  reg_addr,
    input  logic [dsic_pkg::DATA_W-1:0]  reg_wdata,
    input  logic                         reg_wr,
    input  logic                         reg_rd,
    output logic [dsic_pkg::DATA_W-1:0]  reg_rdata,
    input  logic                         txd,
    input  logic                         rts_n,
    input  logic                         dtr_n,
    input  logic                         ext_tx_clock_in,
    input  logic                         ring_detect,
    input  logic [dsic_pkg::LVL_W-1:0]   rx_energy,
    input  logic                         rx_training,
    input  logic                         rx_bit_in,
    output logic                         rxd,
    output logic                         cts_n,
    output logic                         rlsd_n,
    output logic                         dsr_n,
    output logic                         ri_n,
    output logic                         tx_bit_clock_out,
    output logic                         rx_bit_clock_out,
    output logic                         tx_bit,
    output logic                         tx_bit_strobe,
    output logic                         carrier_on,
    output logic                         rx_on,
    output logic                         answer_tone,
    output logic                         train_active
);
    import dsic_pkg::*;

    localparam int TRAIN_W = $clog2(TRAIN_CYCLES + 1);

    // ------------------------------------------------------------
    // State
    // ------------------------------------------------------------
    typedef enum logic [1:0] {
        ST_IDLE,
        ST_HANDSHAKE,
        ST_DATA
    } dsic_state_e;

    typedef struct packed {
        logic [CTRL_W-1:0]    ctrl;
        logic [CFG_W-1:0]     clkcfg;
        logic [LVL_W-1:0]     thr_on;
        logic [LVL_W-1:0]     thr_off;
        logic [RATE_W-1:0]    rate;
        logic [DATA_W-1:0]    rdata;
        dsic_state_e          state;
        logic                 rts_prev;
        logic                 training;
        logic [TRAIN_W-1:0]   train_cnt;
        logic [CTS_CNT_W-1:0] cts_cnt;
        logic                 cts_n;
        logic                 rlsd;
        logic                 rlsd_n;
        logic                 dsr_n;
        logic                 ri_n;
        logic                 carrier;
        logic                 rx_on;
        logic                 answer;
        logic                 rxd;
        logic                 tx_clk;
        logic                 tx_clk_prev;
        logic                 tx_bit;
        logic                 tx_strobe;
    } dsic_top_s;

    dsic_top_s r;
    dsic_top_s n;

    // ------------------------------------------------------------
    // Pin synchronisers
    // ------------------------------------------------------------
    logic txd_s;
    logic rts_n_s;
    logic dtr_n_s;
    logic ext_clk_s;
    logic ring_s;

    dsic_sync #(
        .W       (5),
        .RST_VAL (5'h0F)
    ) u_sync (
        .clk   (clk),
        .reset (reset),
        .d     ({ring_detect, ext_tx_clock_in, dtr_n, rts_n, txd}),
        .q     ({ring_s, ext_clk_s, dtr_n_s, rts_n_s, txd_s})
    );

    // ------------------------------------------------------------
    // Bit clocks
    // ------------------------------------------------------------
    logic int_clk_lvl;
    logic rx_clk_lvl;
    logic rx_fall;

    dsic_bitclk u_txgen (
        .clk        (clk),
        .reset      (reset),
        .enable     (1'b1),
        .half_count (r.rate),
        .level      (int_clk_lvl),
        .rise       (),
        .fall       ()
    );

    // Receive clock runs only in data state so that it restarts in step with it.
    dsic_bitclk u_rxgen (
        .clk        (clk),
        .reset      (reset),
        .enable     (r.state == ST_DATA),
        .half_count (r.rate),
        .level      (rx_clk_lvl),
        .rise       (),
        .fall       (rx_fall)
    );

    // ------------------------------------------------------------
    // Effective handshake levels
    // ------------------------------------------------------------
    logic rts_eff;
    logic dtr_eff;
    logic low_speed;
    logic half_dup;
    logic ctl_carrier;
    logic [1:0] lvl_sel;
    logic [1:0] txsrc_sel;
    logic [LVL_W-1:0] lvl_on;
    logic [LVL_W-1:0] lvl_off;

    assign rts_eff     = !rts_n_s || r.ctrl[CTRL_RTS];
    assign dtr_eff     = !dtr_n_s || r.ctrl[CTRL_DTR];
    assign low_speed   = r.ctrl[CTRL_LOW];
    assign half_dup    = r.ctrl[CTRL_HALF];
    assign ctl_carrier = r.ctrl[CTRL_CCAR];
    assign lvl_sel     = r.clkcfg[CFG_LVL_LSB +: 2];
    assign txsrc_sel   = r.clkcfg[CFG_TXSRC_LSB +: 2];
    assign lvl_on      = thr_pick(lvl_sel, r.thr_on, 1'b1);
    assign lvl_off     = thr_pick(lvl_sel, r.thr_off, 1'b0);

    // ------------------------------------------------------------
    // Next state
    // ------------------------------------------------------------
    always_comb begin
        n           = r;
        n.rdata     = '0;
        n.tx_strobe = 1'b0;

        // Register writes.
        if (reg_wr) begin
            case (reg_addr)
                OFS_CTRL: begin
                    n.ctrl = reg_wdata[CTRL_W-1:0];
                end
                OFS_CLKCFG: begin
                    n.clkcfg = reg_wdata[CFG_W-1:0];
                end
                OFS_THR: begin
                    n.thr_on  = reg_wdata[LVL_W-1:0];
                    n.thr_off = reg_wdata[THR_OFF_LSB +: LVL_W];
                end
                OFS_RATE: begin
                    n.rate = reg_wdata[RATE_W-1:0];
                end
                default: begin
                end
            endcase
        end

        // Register reads; unmapped addresses read as zero.
        if (reg_rd) begin
            case (reg_addr)
                OFS_CTRL: begin
                    n.rdata[CTRL_W-1:0] = r.ctrl;
                end
                OFS_CLKCFG: begin
                    n.rdata[CFG_W-1:0] = r.clkcfg;
                end
                OFS_THR: begin
                    n.rdata[LVL_W-1:0]              = r.thr_on;
                    n.rdata[THR_OFF_LSB +: LVL_W]   = r.thr_off;
                end
                OFS_RATE: begin
                    n.rdata[RATE_W-1:0] = r.rate;
                end
                OFS_STATUS: begin
                    n.rdata[STAT_DSR]   = !r.dsr_n;
                    n.rdata[STAT_RI]    = !r.ri_n;
                    n.rdata[STAT_CTS]   = !r.cts_n;
                    n.rdata[STAT_RLSD]  = !r.rlsd_n;
                    n.rdata[STAT_CAR]   = r.carrier;
                    n.rdata[STAT_DATA]  = r.state == ST_DATA;
                    n.rdata[STAT_TRAIN] = r.training;
                end
                default: begin
                end
            endcase
        end

        // Connection state.
        unique case (r.state)
            ST_IDLE: begin
                if (dtr_eff && low_speed && r.ctrl[CTRL_DATA]) begin
                    n.state = ST_DATA;
                end else if (dtr_eff && !low_speed) begin
                    n.state = ST_HANDSHAKE;
                end
            end
            ST_HANDSHAKE: begin
                if (!dtr_eff) begin
                    n.state = ST_IDLE;
                end else if (r.ctrl[CTRL_DATA]) begin
                    n.state = ST_DATA;
                end
            end
            ST_DATA: begin
                if (!dtr_eff) begin
                    n.state = ST_IDLE;
                end
            end
        endcase

        // Half-duplex training on each new request to send.
        n.rts_prev = rts_eff;
        if (r.state != ST_DATA) begin
            n.training  = 1'b0;
            n.train_cnt = '0;
        end else if (half_dup && rts_eff && !r.rts_prev) begin
            n.training  = 1'b1;
            n.train_cnt = TRAIN_W'(TRAIN_CYCLES - 1);
        end else if (r.training) begin
            if (r.train_cnt == '0) begin
                n.training = 1'b0;
            end else begin
                n.train_cnt = r.train_cnt - 1'b1;
            end
        end

        // Clear to send follows the request after a fixed response delay.
        if (r.state == ST_DATA && rts_eff && !r.training) begin
            if (r.cts_cnt != CTS_CNT_W'(CTS_DELAY_CYC)) begin
                n.cts_cnt = r.cts_cnt + 1'b1;
            end
        end else begin
            n.cts_cnt = '0;
        end
        n.cts_n = !(r.state == ST_DATA && rts_eff && !r.training
                    && r.cts_cnt == CTS_CNT_W'(CTS_DELAY_CYC));

        // Transmitter and receiver enables.
        n.carrier = (r.state == ST_HANDSHAKE) || r.training
                    || (r.state == ST_DATA && (!(low_speed && ctl_carrier) || rts_eff));
        n.rx_on   = r.state != ST_IDLE;
        n.answer  = r.state == ST_DATA && low_speed && r.ctrl[CTRL_ANSWER];

        // Interchange status outputs.
        n.dsr_n = !(r.state == ST_DATA && !r.ctrl[CTRL_TEST]);
        n.ri_n  = !ring_s;

        // Hysteresis keeps the detector from chattering near the threshold.
        if (!r.rlsd && !rx_training && rx_energy > lvl_on) begin
            n.rlsd = 1'b1;
        end else if (r.rlsd && (rx_training || rx_energy < lvl_off)) begin
            n.rlsd = 1'b0;
        end
        n.rlsd_n = !r.rlsd;

        // Received data changes on the falling receive clock edge.
        if (r.state != ST_DATA) begin
            n.rxd = 1'b1;
        end else if (rx_fall) begin
            n.rxd = rx_bit_in;
        end

        // Transmit clock source.
        unique case (txsrc_sel)
            TXSRC_EXT: begin
                n.tx_clk = ext_clk_s;
            end
            TXSRC_SLAVE: begin
                n.tx_clk = rx_clk_lvl;
            end
            default: begin
                n.tx_clk = int_clk_lvl;
            end
        endcase

        // Terminal moves TXD on the falling edge, so the rising edge is mid bit.
        n.tx_clk_prev = r.tx_clk;
        if (r.tx_clk && !r.tx_clk_prev && !r.cts_n) begin
            n.tx_bit    = txd_s;
            n.tx_strobe = 1'b1;
        end
    end

    // ------------------------------------------------------------
    // Registers
    // ------------------------------------------------------------
    always_ff @(posedge clk) begin
        if (reset) begin
            r             <= '0;
            r.ctrl        <= CTRL_RST;
            r.clkcfg      <= CLKCFG_RST;
            r.thr_on      <= THR_ON_RST;
            r.thr_off     <= THR_OFF_RST;
            r.rate        <= RATE_RST;
            r.state       <= ST_IDLE;
            r.rts_prev    <= 1'b0;
            r.cts_n       <= 1'b1;
            r.rlsd_n      <= 1'b1;
            r.dsr_n       <= 1'b1;
            r.ri_n        <= 1'b1;
            r.rxd         <= 1'b1;
            r.tx_bit      <= 1'b1;
        end else begin
            r <= n;
        end
    end

    // ------------------------------------------------------------
    // Outputs
    // ------------------------------------------------------------
    assign reg_rdata        = r.rdata;
    assign rxd              = r.rxd;
    assign cts_n            = r.cts_n;
    assign rlsd_n           = r.rlsd_n;
    assign dsr_n            = r.dsr_n;
    assign ri_n             = r.ri_n;
    assign tx_bit_clock_out = r.tx_clk;
    assign rx_bit_clock_out = rx_clk_lvl;
    assign tx_bit           = r.tx_bit;
    assign tx_bit_strobe    = r.tx_strobe;
    assign carrier_on       = r.carrier;
    assign rx_on            = r.rx_on;
    assign answer_tone      = r.answer;
    assign train_active     = r.training;

endmodule

// ### sim/dsic_top_checker.sv
module dsic_top_checker #(
    parameter int TRAIN_CYCLES = 20
) (
    input  logic  clk,
    input  logic  reset,
    input  logic  ring_detect,
    input  logic  rx_training,
    input  logic  ri_n,
    input  logic  cts_n,
    input  logic  dsr_n,
    input  logic  rlsd_n,
    input  logic  rx_on,
    input  logic  rxd,
    input  logic  rx_bit_clock_out,
    input  logic  tx_bit_clock_out,
    input  logic  tx_bit_strobe,
    input  logic  answer_tone,
    input  logic  train_active
);
    timeunit 1ns;
    timeprecision 1ps;
    // --------
    // Properties
    // --------
    default clocking @(posedge clk); endclocking
    default disable iff (reset);
    int train_len;
    always_ff @(posedge clk) train_len <= (reset || !train_active) ? 0 : train_len + 1;
    a_ri_ring_on: assert property (ring_detect [*4] |=> !ri_n) else $error("ri low missing");
    a_ri_ring_off: assert property (!ring_detect [*4] |=> ri_n) else $error("ri high missing");
    a_rlsd_no_train: assert property (rx_training |-> ##2 rlsd_n) else $error("rlsd in training");
    a_dsr_only_data: assert property (!dsr_n |-> rx_on) else $error("dsr outside data");
    a_tone_in_data: assert property (answer_tone |-> rx_on) else $error("tone while idle");
    a_rx_clock_idle: assert property (!rx_on [*2] |-> !rx_bit_clock_out) else $error("rx clock idle");
    a_rxd_idle_mark: assert property (!rx_on [*2] |-> rxd) else $error("rxd not mark");
    a_rxd_on_fall: assert property ($changed(rxd) && rx_on && $past(rx_on, 2) |-> $fell(rx_bit_clock_out))
        else $error("rxd moved off fall");
    a_strobe_at_rise: assert property (tx_bit_strobe |-> tx_bit_clock_out && !$past(tx_bit_clock_out, 2))
        else $error("strobe not at rise");
    a_strobe_single: assert property (tx_bit_strobe |=> !tx_bit_strobe) else $error("strobe too long");
    a_no_cts_train: assert property (train_active |-> cts_n) else $error("cts during training");
    a_train_length: assert property ($fell(train_active) |-> train_len == TRAIN_CYCLES)
        else $error("training length");
endmodule

// ### sim/dsic_dte_model.sv
module dsic_dte_model (
    input  logic  run,
    input  logic  cts_n,
    output logic  ext_tx_clock_in,
    output logic  txd
);
    timeunit 1ns;
    timeprecision 1ps;
    // --------
    // Terminal transmit side
    // --------
    int seed = 32'h5DB1;
    // The clock stands still low outside a frame; a period once begun is always completed.
    initial begin
        ext_tx_clock_in = 1'b0;
        txd = 1'b1;
        #7;
        forever begin
            if (run) begin
                #80 ext_tx_clock_in = 1'b1;
                #80 ext_tx_clock_in = 1'b0;
                txd = cts_n ? 1'b1 : 1'($random(seed));
            end else begin
                #20;
            end
        end
    end
endmodule

// ### sim/dsic_top_tb_top.sv
module dsic_top_tb_top;
    timeunit 1ns;
    timeprecision 1ps;
    import dsic_pkg::*;
    localparam int TRAIN_CYCLES = 20;
    // --------
    // Signals and instances
    // --------
    logic clk = 1'b0, reset = 1'b1, reg_wr = 1'b0, reg_rd = 1'b0, rts_n = 1'b1, dtr_n = 1'b1;
    logic ring_detect = 1'b0, rx_training = 1'b0, rx_bit_in = 1'b0, run = 1'b0, tx_mon = 1'b0, rx_mon = 1'b0;
    logic [ADDR_W-1:0] reg_addr = '0;
    logic [DATA_W-1:0] reg_wdata = '0, reg_rdata;
    logic [LVL_W-1:0] rx_energy = '0;
    logic txd, ext_tx_clock_in, rxd, cts_n, rlsd_n, dsr_n, ri_n, tx_bit_clock_out, rx_bit_clock_out, rb_q, rc_q;
    logic tx_bit, tx_bit_strobe, carrier_on, rx_on, answer_tone, train_active;
    logic tx_q[$];
    int seed = 32'h5DB1, err_count = 0, n_compared = 0;
    int on_l[4] = '{32, 48, 64, 96};
    int off_l[4] = '{26, 40, 54, 80};
    dsic_top #(.TRAIN_CYCLES(TRAIN_CYCLES)) i_dut (.clk(clk), .reset(reset), .reg_addr(reg_addr),
        .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .txd(txd),
        .rts_n(rts_n), .dtr_n(dtr_n), .ext_tx_clock_in(ext_tx_clock_in), .ring_detect(ring_detect),
        .rx_energy(rx_energy), .rx_training(rx_training), .rx_bit_in(rx_bit_in), .rxd(rxd), .cts_n(cts_n),
        .rlsd_n(rlsd_n), .dsr_n(dsr_n), .ri_n(ri_n), .tx_bit_clock_out(tx_bit_clock_out),
        .rx_bit_clock_out(rx_bit_clock_out), .tx_bit(tx_bit), .tx_bit_strobe(tx_bit_strobe),
        .carrier_on(carrier_on), .rx_on(rx_on), .answer_tone(answer_tone), .train_active(train_active));
    dsic_dte_model i_dte (.run(run), .cts_n(cts_n), .ext_tx_clock_in(ext_tx_clock_in), .txd(txd));
    initial forever #10 clk = ~clk;
    // --------
    // Tasks
    // --------
    task automatic chk(input logic [31:0] got, exp);
        n_compared++;
        if (got !== exp) begin
            err_count++;
            $display("[ERR] %0t got %0h exp %0h", $time, got, exp);
        end
    endtask
    task automatic finish_test();
        $display("compared %0d mismatched %0d", n_compared, err_count);
        if (err_count == 0 && n_compared > 0) $display("Finished cleanly");
        else $display("Finished with errors");
        $finish;
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        reg_addr <= a;
        reg_wdata <= d;
        reg_wr <= 1'b1;
        @(posedge clk);
        reg_wr <= 1'b0;
        @(posedge clk);
    endtask
    task automatic rd_chk(input logic [7:0] a, input logic [31:0] exp);
        reg_addr <= a;
        reg_rd <= 1'b1;
        @(posedge clk);
        reg_rd <= 1'b0;
        @(negedge clk);
        chk(reg_rdata, exp);
        @(posedge clk);
    endtask
    // Levels are looked at on the falling edge, clear of the edge that updates them.
    task automatic wait_lvl(ref logic s, input logic v);
        int n = 0;
        @(negedge clk);
        while (s !== v) begin
            n++;
            if (n > 6000) begin
                err_count++;
                $display("[ERR] %0t wait ran out", $time);
                finish_test();
            end
            @(negedge clk);
        end
        @(posedge clk);
    endtask
    task automatic measure(ref logic s, input int half);
        int hi = 1, lo = 1;
        wait_lvl(s, 1'b0);
        wait_lvl(s, 1'b1);
        @(negedge clk);
        while (s === 1'b1 && hi < 6000) begin hi++; @(negedge clk); end
        @(negedge clk);
        while (s === 1'b0 && lo < 6000) begin lo++; @(negedge clk); end
        chk(hi, half);
        chk(lo, half);
        @(posedge clk);
    endtask
    // --------
    // Stream models
    // --------
    always @(posedge clk) rx_bit_in <= 1'($random(seed));
    always @(posedge clk) rb_q <= rx_bit_in;
    always @(posedge ext_tx_clock_in) if (tx_mon && cts_n === 1'b0) tx_q.push_back(txd);
    always @(negedge clk) begin
        if (tx_mon && tx_bit_strobe === 1'b1) chk(tx_bit, tx_q.size() ? tx_q.pop_front() : 1'bx);
        if (rx_mon && rc_q === 1'b1 && rx_bit_clock_out === 1'b0) chk(rxd, rb_q);
        rc_q <= rx_bit_clock_out;
    end
    // --------
    // Main sequence
    // --------
    initial begin
        repeat (10) @(posedge clk);
        reset <= 1'b0;
        rd_chk(OFS_CTRL, 0);
        rd_chk(OFS_CLKCFG, 0);
        rd_chk(OFS_THR, 32'h3040);
        rd_chk(OFS_RATE, 32'h0A2C);
        rd_chk(OFS_STATUS, 0);
        wr(OFS_RATE, 5);
        wr(OFS_THR, 32'h5060);
        for (int i = 0; i < 4; i++) begin
            wr(OFS_CLKCFG, i << CFG_LVL_LSB);
            rx_energy <= 8'(on_l[i]);
            repeat (4) @(posedge clk);
            chk(rlsd_n, 1);
            rx_energy <= 8'(on_l[i] + 1);
            wait_lvl(rlsd_n, 1'b0);
            rx_energy <= 8'(off_l[i]);
            repeat (4) @(posedge clk);
            chk(rlsd_n, 0);
            rx_energy <= 8'(off_l[i] - 1);
            wait_lvl(rlsd_n, 1'b1);
        end
        rx_energy <= 8'hFF;
        rx_training <= 1'b1;
        repeat (4) @(posedge clk);
        chk(rlsd_n, 1);
        rx_training <= 1'b0;
        wait_lvl(rlsd_n, 1'b0);
        rx_energy <= 8'h00;
        ring_detect <= 1'b1;
        wait_lvl(ri_n, 1'b0);
        rd_chk(OFS_STATUS, 32'h2);
        ring_detect <= 1'b0;
        wait_lvl(ri_n, 1'b1);
        wr(OFS_CTRL, 32'h3C);
        dtr_n <= 1'b0;
        wait_lvl(dsr_n, 1'b0);
        chk(answer_tone, 1);
        chk(carrier_on, 0);
        rts_n <= 1'b0;
        wait_lvl(cts_n, 1'b0);
        chk(carrier_on, 1);
        rd_chk(OFS_STATUS, 32'h35);
        measure(tx_bit_clock_out, 5);
        measure(rx_bit_clock_out, 5);
        wr(OFS_CLKCFG, TXSRC_SLAVE);
        measure(tx_bit_clock_out, 5);
        wr(OFS_CLKCFG, TXSRC_EXT);
        repeat (2) @(posedge clk);
        tx_mon <= 1'b1;
        rx_mon <= 1'b1;
        run <= 1'b1;
        measure(tx_bit_clock_out, 4);
        repeat (200) @(posedge clk);
        run <= 1'b0;
        repeat (50) @(posedge clk);
        tx_mon <= 1'b0;
        rx_mon <= 1'b0;
        chk(tx_q.size(), 0);
        rts_n <= 1'b1;
        wait_lvl(cts_n, 1'b1);
        wr(OFS_CTRL, 32'hBC);
        wait_lvl(dsr_n, 1'b1);
        wr(OFS_CTRL, 32'h3C);
        wait_lvl(dsr_n, 1'b0);
        dtr_n <= 1'b1;
        wait_lvl(rx_on, 1'b0);
        chk({dsr_n, answer_tone, carrier_on}, 3'b100);
        wr(OFS_CTRL, 32'h02);
        wait_lvl(rx_on, 1'b1);
        repeat (20) @(posedge clk);
        chk(dsr_n, 1);
        wr(OFS_CTRL, 32'h06);
        wait_lvl(dsr_n, 1'b0);
        wr(OFS_CTRL, 32'h46);
        wr(OFS_CTRL, 32'h47);
        wait_lvl(train_active, 1'b1);
        chk(cts_n, 1);
        wait_lvl(cts_n, 1'b0);
        wr(8'h14, 32'hFFFF_FFFF);
        rd_chk(8'h14, 0);
        rd_chk(OFS_CTRL, 32'h47);
        wr(OFS_CTRL, 0);
        wait_lvl(rx_on, 1'b0);
        finish_test();
    end
endmodule
bind dsic_top dsic_top_checker #(.TRAIN_CYCLES(TRAIN_CYCLES)) i_chk (.clk(clk), .reset(reset),
    .ring_detect(ring_detect), .rx_training(rx_training), .ri_n(ri_n), .cts_n(cts_n), .dsr_n(dsr_n),
    .rlsd_n(rlsd_n), .rx_on(rx_on), .rxd(rxd), .rx_bit_clock_out(rx_bit_clock_out),
    .tx_bit_clock_out(tx_bit_clock_out), .tx_bit_strobe(tx_bit_strobe), .answer_tone(answer_tone),
    .train_active(train_active));
